// *** host_port_pin_map.vh ***
// Register offsets, field positions and reset values of the host port pin block
`ifndef HOST_PORT_PIN_MAP_VH
`define HOST_PORT_PIN_MAP_VH

`define HP_ADDR_W           8
`define HP_OFF_CONTROL      8'h00
`define HP_OFF_FSEL_LO      8'h04
`define HP_OFF_FSEL_HI      8'h08
`define HP_OFF_DIR_1        8'h0c
`define HP_OFF_DIR_2        8'h10
`define HP_OFF_DIR_3        8'h14
`define HP_OFF_LEVEL_1      8'h18
`define HP_OFF_LEVEL_2      8'h1c
`define HP_OFF_LEVEL_3      8'h20
`define HP_OFF_STB_INT_1    8'h24
`define HP_OFF_STB_INT_2    8'h28
`define HP_OFF_PWR_EMU      8'h2c
`define HP_OFF_STATUS       8'h30

`define HP_CTRL_SOFT_RST    7
`define HP_CTRL_READY       3
`define HP_STB_INT_EN       0
`define HP_STB_INT_INV      0
`define HP_EMU_FREE         0
`define HP_EMU_SOFT         1
`define HP_ST_HALTED        0
`define HP_ST_STOPPED       1
`define HP_ST_SRST_BUSY     2
`define HP_ST_STB_LEVEL     3

`define HP_NUM_PINS         41
`define HP_PIN_DATA_LO      0
`define HP_PIN_ADDR_LO      16
`define HP_PIN_BYTE_HALF    32
`define HP_PIN_ADDR_STROBE  33
`define HP_PIN_ACC_TYPE_0   34
`define HP_PIN_ACC_TYPE_1   35
`define HP_PIN_HOST_INT     36
`define HP_PIN_DSTROBE_1    37
`define HP_PIN_DSTROBE_2    38
`define HP_PIN_PORT_SEL     39
`define HP_PIN_RW_SEL       40

`define HP_RST_FSEL         41'h000_0000_0000
`define HP_RST_DIR          16'h0000
`define HP_RST_LEVEL        16'h0000

`endif

// *** host_port_pin_io.v ***
// Host port pin ownership, general-purpose I/O, suspend, idle and reset sequencing
// What this block does
// - Small variant, 8-bit mux: low pins port-GPIO
// - Small variant, mux off: those pins leave port
// - Type/interrupt pins always; strobes only when disabled
// - Ready and port enable pins never GPIO
// - Large variant 8-bit mux: only low pins GPIO
// - Large variant 16-bit mux: all address/data GPIO
// - Per-pin enable selects port function or GPIO
// - Per-pin direction bit: input or driven output
// - Level bit: reads pin input, drives output
// - Address strobe input can interrupt, optionally inverted
// - Granted idle mode stops all activity at once
// - Free-run set, or both clear: suspend ignored
// - Soft-stop suspend halts transfers after current work
// - Host interface keeps working during soft-stop suspend
// - Blocked host cycle keeps ready low in suspend
// - Suspend end requests draining and refilling transfers
// - Device reset: ready low, or finish active cycle
// - Device reset clears registers, FIFOs, interrupts, pins
// - Soft reset: drain transfers, finish host cycle first
// - Soft reset then clears FIFOs and their pointers
// - Soft reset bit reads 0; zero write ignored
// - Soft reset leaves other registers untouched
// - Soft reset is control bit 7, write-one
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
`include "host_port_pin_map.vh"

module host_port_pin_io #(
  parameter LARGE_VARIANT = 0
) (
  input  wire                     clk_i,
  input  wire                     rst_i,
  input  wire                     psel_i,
  input  wire                     penable_i,
  input  wire                     pwrite_i,
  input  wire [`HP_ADDR_W-1:0]    paddr_i,
  input  wire [31:0]              pwdata_i,
  output reg  [31:0]              prdata_o,
  output reg                      pready_o,
  output reg                      pslverr_o,
  input  wire                     mux8_mode_i,
  input  wire                     mux16_mode_i,
  input  wire                     port_enable_pin_i,
  input  wire                     host_strobe_internal_n_i,
  input  wire                     fifo_ready_i,
  input  wire                     dma_busy_i,
  input  wire                     emu_suspend_i,
  input  wire                     idle_grant_i,
  input  wire [`HP_NUM_PINS-1:0]  pin_in_i,
  output reg  [`HP_NUM_PINS-1:0]  pin_out_o,
  output reg  [`HP_NUM_PINS-1:0]  pin_oe_n_o,
  output reg  [`HP_NUM_PINS-1:0]  pin_gpio_sel_o,
  output reg                      host_ready_o,
  output reg                      fifo_reset_o,
  output reg                      dma_halt_o,
  output reg                      resume_request_o,
  output reg                      port_stop_o,
  output reg                      clear_interrupts_o,
  output reg                      strobe_event_o
);

  localparam NP = `HP_NUM_PINS;
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_DRAIN = 4'b0010;
  localparam [3:0] S_HOLD  = 4'b0100;
  localparam [3:0] S_FLUSH = 4'b1000;

  reg  [NP-1:0]  sync_1;
  reg  [NP-1:0]  sync_2;
  reg  [NP-1:0]  sync_3;
  reg  [NP-1:0]  pin_level;
  reg  [2:0]     enable_sync;
  reg            port_enabled;
  reg  [NP-1:0]  fsel;
  reg  [15:0]    dir_1;
  reg  [15:0]    dir_2;
  reg  [8:0]     dir_3;
  reg  [15:0]    level_1;
  reg  [15:0]    level_2;
  reg  [8:0]     level_3;
  reg            stb_int_en;
  reg            stb_int_inv;
  reg            emu_free;
  reg            emu_soft;
  reg  [3:0]     srst_state;
  reg            srst_host_active;
  reg            rst_strobe_seen;
  reg            stb_prev;
  reg  [NP-1:0]  capable;
  reg  [NP-1:0]  dir_all;
  reg  [NP-1:0]  level_all;
  reg  [NP-1:0]  level_read;
  reg  [31:0]    next_rdata;
  reg            next_err;
  reg            next_ready;
  reg  [3:0]     next_srst_state;
  wire           acc_phase;
  wire           wr_en;
  wire           soft_stop;
  wire           stb_level;
  wire           stb_gpio_in;

  assign acc_phase = psel_i & penable_i;
  assign wr_en     = acc_phase & pwrite_i & pready_o;
  assign soft_stop = emu_suspend_i & ~emu_free & emu_soft;
  assign stb_level = pin_level[`HP_PIN_ADDR_STROBE] ^ stb_int_inv;
  assign stb_gpio_in = capable[`HP_PIN_ADDR_STROBE] & fsel[`HP_PIN_ADDR_STROBE] &
                       ~dir_all[`HP_PIN_ADDR_STROBE];

  // Pin inputs: three flops, a change counts once stages two and three agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_1       <= {NP{1'b0}};
      sync_2       <= {NP{1'b0}};
      sync_3       <= {NP{1'b0}};
      pin_level    <= {NP{1'b0}};
      enable_sync  <= 3'h0;
      port_enabled <= 1'b0;
    end else begin
      sync_1       <= pin_in_i;
      sync_2       <= sync_1;
      sync_3       <= sync_2;
      pin_level    <= (sync_2 & sync_3) | (pin_level & (sync_2 ^ sync_3));
      enable_sync  <= {enable_sync[1:0], port_enable_pin_i};
      if (enable_sync[1] == enable_sync[2]) begin
        port_enabled <= enable_sync[1];
      end
    end
  end

  // Which pins the port may hand over to general-purpose I/O
  always @* begin
    capable = {NP{1'b0}};
    capable[`HP_PIN_ACC_TYPE_0] = 1'b1;
    capable[`HP_PIN_ACC_TYPE_1] = 1'b1;
    capable[`HP_PIN_HOST_INT]   = 1'b1;
    capable[`HP_PIN_DSTROBE_1]  = ~port_enabled;
    capable[`HP_PIN_DSTROBE_2]  = ~port_enabled;
    capable[`HP_PIN_PORT_SEL]   = ~port_enabled;
    capable[`HP_PIN_RW_SEL]     = ~port_enabled;
    if (LARGE_VARIANT != 0 && mux16_mode_i) begin
      capable[31:0] = 32'hffff_ffff;
    end else if (mux8_mode_i) begin
      // Upper data and address stay with external memory in this mode
      capable[7:0]                  = 8'hff;
      capable[`HP_PIN_BYTE_HALF]    = 1'b1;
      capable[`HP_PIN_ADDR_STROBE]  = 1'b1;
    end
    // Otherwise the low group belongs to system pin control
    // Ready and port enable have no slot in the pin vector
    dir_all    = {dir_3, dir_2, dir_1};
    level_all  = {level_3, level_2, level_1};
    level_read = (dir_all & level_all) | (~dir_all & pin_level);
  end

  // Register read decode
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr_i == `HP_OFF_CONTROL) begin
      next_rdata[`HP_CTRL_READY] = host_ready_o; // Soft reset bit always reads 0
    end else if (paddr_i == `HP_OFF_FSEL_LO) begin
      next_rdata = fsel[31:0];
    end else if (paddr_i == `HP_OFF_FSEL_HI) begin
      next_rdata[8:0] = fsel[NP-1:32];
    end else if (paddr_i == `HP_OFF_DIR_1) begin
      next_rdata[15:0] = dir_1;
    end else if (paddr_i == `HP_OFF_DIR_2) begin
      next_rdata[15:0] = dir_2;
    end else if (paddr_i == `HP_OFF_DIR_3) begin
      next_rdata[8:0] = dir_3;
    end else if (paddr_i == `HP_OFF_LEVEL_1) begin
      next_rdata[15:0] = level_read[15:0];
    end else if (paddr_i == `HP_OFF_LEVEL_2) begin
      next_rdata[15:0] = level_read[31:16];
    end else if (paddr_i == `HP_OFF_LEVEL_3) begin
      next_rdata[8:0] = level_read[NP-1:32];
    end else if (paddr_i == `HP_OFF_STB_INT_1) begin
      next_rdata[`HP_STB_INT_EN] = stb_int_en;
    end else if (paddr_i == `HP_OFF_STB_INT_2) begin
      next_rdata[`HP_STB_INT_INV] = stb_int_inv;
    end else if (paddr_i == `HP_OFF_PWR_EMU) begin
      next_rdata[`HP_EMU_FREE] = emu_free;
      next_rdata[`HP_EMU_SOFT] = emu_soft;
    end else if (paddr_i == `HP_OFF_STATUS) begin
      next_rdata[`HP_ST_HALTED]    = dma_halt_o;
      next_rdata[`HP_ST_STOPPED]   = port_stop_o;
      next_rdata[`HP_ST_SRST_BUSY] = ~srst_state[0];
      next_rdata[`HP_ST_STB_LEVEL] = stb_level;
    end else begin
      next_err = 1'b1;
    end
  end

  // APB slave: one wait state in the access phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc_phase & ~pready_o;
      if (acc_phase & ~pready_o) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
        pslverr_o <= next_err;
      end else begin
        prdata_o  <= 32'h0000_0000;
        pslverr_o <= 1'b0;
      end
    end
  end

  // Configuration registers; soft reset never touches them
  always @(posedge clk_i) begin
    if (rst_i) begin
      fsel        <= `HP_RST_FSEL;
      dir_1       <= `HP_RST_DIR;
      dir_2       <= `HP_RST_DIR;
      dir_3       <= 9'h000;
      level_1     <= `HP_RST_LEVEL;
      level_2     <= `HP_RST_LEVEL;
      level_3     <= 9'h000;
      stb_int_en  <= 1'b0;
      stb_int_inv <= 1'b0;
      emu_free    <= 1'b0;
      emu_soft    <= 1'b0;
    end else if (wr_en) begin
      if (paddr_i == `HP_OFF_FSEL_LO) begin
        fsel[31:0] <= pwdata_i;
      end else if (paddr_i == `HP_OFF_FSEL_HI) begin
        fsel[NP-1:32] <= pwdata_i[8:0];
      end else if (paddr_i == `HP_OFF_DIR_1) begin
        dir_1 <= pwdata_i[15:0];
      end else if (paddr_i == `HP_OFF_DIR_2) begin
        dir_2 <= pwdata_i[15:0];
      end else if (paddr_i == `HP_OFF_DIR_3) begin
        dir_3 <= pwdata_i[8:0];
      end else if (paddr_i == `HP_OFF_LEVEL_1) begin
        level_1 <= pwdata_i[15:0];
      end else if (paddr_i == `HP_OFF_LEVEL_2) begin
        level_2 <= pwdata_i[15:0];
      end else if (paddr_i == `HP_OFF_LEVEL_3) begin
        level_3 <= pwdata_i[8:0];
      end else if (paddr_i == `HP_OFF_STB_INT_1) begin
        stb_int_en <= pwdata_i[`HP_STB_INT_EN];
      end else if (paddr_i == `HP_OFF_STB_INT_2) begin
        stb_int_inv <= pwdata_i[`HP_STB_INT_INV];
      end else if (paddr_i == `HP_OFF_PWR_EMU) begin
        emu_free <= pwdata_i[`HP_EMU_FREE];
        emu_soft <= pwdata_i[`HP_EMU_SOFT];
      end
    end
  end

  // Pin drive: only capable, selected output pins are driven
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o      <= {NP{1'b0}};
      pin_oe_n_o     <= {NP{1'b1}};
      pin_gpio_sel_o <= {NP{1'b0}};
    end else begin
      pin_out_o      <= level_all & capable & fsel;
      pin_oe_n_o     <= ~(capable & fsel & dir_all);
      pin_gpio_sel_o <= capable & fsel;
    end
  end

  // Address strobe as an interrupt source, rising edge after optional inversion
  always @(posedge clk_i) begin
    if (rst_i) begin
      stb_prev       <= 1'b0;
      strobe_event_o <= 1'b0;
    end else begin
      stb_prev       <= stb_level;
      strobe_event_o <= stb_int_en & stb_level & ~stb_prev & ~port_stop_o & stb_gpio_in;
    end
  end

  // Idle mode and emulation suspend
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_stop_o      <= 1'b0;
      dma_halt_o       <= 1'b0;
      resume_request_o <= 1'b0;
    end else begin
      port_stop_o <= idle_grant_i;
      if (idle_grant_i) begin
        dma_halt_o <= 1'b1;
      end else if (!soft_stop) begin
        dma_halt_o <= 1'b0;
      end else if (!dma_busy_i && host_strobe_internal_n_i) begin
        dma_halt_o <= 1'b1;
      end
      resume_request_o <= dma_halt_o & ~soft_stop & ~idle_grant_i;
    end
  end

  // Soft reset sequencer
  always @* begin
    next_srst_state = srst_state;
    case (srst_state)
      S_IDLE: begin
        if (wr_en && paddr_i == `HP_OFF_CONTROL && pwdata_i[`HP_CTRL_SOFT_RST]) begin
          next_srst_state = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (!dma_busy_i) begin
          next_srst_state = srst_host_active ? S_HOLD : S_FLUSH;
        end
      end
      S_HOLD: begin
        if (host_strobe_internal_n_i) begin
          next_srst_state = S_FLUSH;
        end
      end
      S_FLUSH: begin
        next_srst_state = S_IDLE;
      end
      default: begin
        next_srst_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      srst_state       <= S_IDLE;
      srst_host_active <= 1'b0;
    end else begin
      srst_state <= next_srst_state; // Zero writes cannot abort
      // Strobe level is latched while idle, so the write edge decides the path
      if (srst_state[0]) begin
        srst_host_active <= ~host_strobe_internal_n_i;
      end
    end
  end

  // Ready and FIFO reset
  always @* begin
    next_ready = 1'b0;
    if (srst_state == S_IDLE) begin
      // Ready is registered, so the soft reset write itself must pull it low
      if (next_srst_state == S_IDLE) begin
        next_ready = fifo_ready_i & ~idle_grant_i;
      end else begin
        next_ready = 1'b0;
      end
    end else if (srst_state == S_HOLD) begin
      next_ready = ~host_strobe_internal_n_i;
    end else if (srst_state == S_DRAIN && !srst_host_active) begin
      next_ready = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      // During reset ready follows the strobe until the host ends its cycle
      rst_strobe_seen    <= rst_strobe_seen | host_strobe_internal_n_i;
      host_ready_o       <= ~host_strobe_internal_n_i & ~rst_strobe_seen;
      fifo_reset_o       <= 1'b1;
      clear_interrupts_o <= 1'b1;
    end else begin
      rst_strobe_seen    <= 1'b0;
      host_ready_o       <= next_ready;
      fifo_reset_o       <= (srst_state == S_FLUSH);
      clear_interrupts_o <= 1'b0;
    end
  end

endmodule // host_port_pin_io

// *** host_port_pin_io_sva.sv ***
// Concurrent checks on the host port pin block ports
`timescale 1ns/10ps
`include "host_port_pin_map.vh"
module host_port_pin_io_sva (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [`HP_ADDR_W-1:0]   paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic [31:0]             prdata_o,
  input wire logic                    pready_o,
  input wire logic                    mux8_mode_i,
  input wire logic                    port_enable_pin_i,
  input wire logic                    host_strobe_internal_n_i,
  input wire logic                    fifo_ready_i,
  input wire logic                    dma_busy_i,
  input wire logic                    emu_suspend_i,
  input wire logic                    idle_grant_i,
  input wire logic [`HP_NUM_PINS-1:0] pin_oe_n_o,
  input wire logic [`HP_NUM_PINS-1:0] pin_gpio_sel_o,
  input wire logic                    host_ready_o,
  input wire logic                    fifo_reset_o,
  input wire logic                    dma_halt_o,
  input wire logic                    resume_request_o,
  input wire logic                    port_stop_o,
  input wire logic                    clear_interrupts_o,
  input wire logic                    strobe_event_o
);
  default clocking cb @(posedge clk_i); endclocking
  sequence s_done;
    psel_i && penable_i && pready_o;
  endsequence
  sequence s_soft_wr;
    s_done ##0 (pwrite_i && paddr_i == `HP_OFF_CONTROL && pwdata_i[7]);
  endsequence
  chk_strobe_pins_held: assert property (disable iff (rst_i)
    port_enable_pin_i [*6] |-> pin_gpio_sel_o[40:37] == 4'h0) else $error("strobe pins left in gpio");
  chk_mux_off_pins: assert property (disable iff (rst_i)
    !mux8_mode_i [*2] |-> pin_gpio_sel_o[7:0] == 8'h00 && pin_gpio_sel_o[33:32] == 2'h0)
    else $error("low pins kept with mux off");
  chk_drive_selected: assert property (disable iff (rst_i)
    &(pin_oe_n_o | pin_gpio_sel_o)) else $error("unselected pin driven");
  chk_reset_idle_ready: assert property (
    (rst_i && host_strobe_internal_n_i) ##1 rst_i |-> !host_ready_o) else $error("ready high in idle reset");
  chk_reset_finish_cycle: assert property (
    (rst_i && !host_strobe_internal_n_i && !$past(rst_i)) ##1 rst_i |-> host_ready_o)
    else $error("ready not raised for active cycle");
  chk_reset_clears_all: assert property (
    rst_i ##1 rst_i |-> fifo_reset_o && clear_interrupts_o && &pin_oe_n_o && !dma_halt_o)
    else $error("reset state wrong");
  chk_soft_flush_seq: assert property (disable iff (rst_i)
    s_soft_wr ##0 (host_strobe_internal_n_i && !dma_busy_i) |=> !host_ready_o ##[0:7] fifo_reset_o)
    else $error("soft reset flush missing");
  chk_flush_after_drain: assert property (disable iff (rst_i)
    $rose(fifo_reset_o) |-> !$past(dma_busy_i)) else $error("flush while transfers pending");
  chk_ctrl_bit_zero: assert property (disable iff (rst_i)
    s_done ##0 (!pwrite_i && paddr_i == `HP_OFF_CONTROL) |-> !prdata_o[7]) else $error("soft reset bit read 1");
  chk_idle_stops_port: assert property (disable iff (rst_i)
    idle_grant_i ##1 idle_grant_i |-> port_stop_o && !host_ready_o) else $error("idle did not stop port");
  chk_blocked_ready_low: assert property (disable iff (rst_i)
    (!fifo_ready_i && host_strobe_internal_n_i) ##1 !fifo_ready_i |-> !host_ready_o)
    else $error("ready high while blocked");
  chk_halt_cause: assert property (disable iff (rst_i)
    $rose(dma_halt_o) |-> $past(idle_grant_i) || ($past(emu_suspend_i) && !$past(dma_busy_i)))
    else $error("halt without suspend");
  chk_resume_after_halt: assert property (disable iff (rst_i)
    $fell(dma_halt_o) |-> resume_request_o) else $error("no resume request");
  chk_event_pulse: assert property (disable iff (rst_i)
    strobe_event_o |-> pin_gpio_sel_o[33] ##1 !strobe_event_o) else $error("bad strobe event");
endmodule // host_port_pin_io_sva

// *** host_model.sv ***
// Behavioural host that runs strobe cycles on the port
`timescale 1ns/10ps
module host_model (
  input  wire logic clk_i,
  input  wire logic host_ready_i,
  output logic      strobe_n_o
);
  initial strobe_n_o = 1'b1;
  // Strobe held low until ready is seen high, then for hold cycles
  task automatic cycle(input int hold);
    @(posedge clk_i) strobe_n_o <= 1'b0;
    while (host_ready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    repeat (hold) @(posedge clk_i);
    strobe_n_o <= 1'b1;
  endtask
endmodule // host_model

// *** host_port_pin_io_tb.sv ***
// Testbench for the host port pin block
`timescale 1ns/10ps
`include "host_port_pin_map.vh"
module host_port_pin_io_tb;
  logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, err;
  logic        mux8_mode_i = 1, mux16_mode_i = 0, port_enable_pin_i = 0, fifo_ready_i = 1, dma_busy_i = 0, strobe_n;
  logic        emu_suspend_i = 0, idle_grant_i = 0, host_ready_o, fifo_reset_o, dma_halt_o;
  logic        resume_request_o, port_stop_o, clear_interrupts_o, strobe_event_o;
  logic [7:0]  paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [40:0] pin_in_i = 0, pin_out_o, pin_oe_n_o, pin_gpio_sel_o;
  int          fail_count = 0, checked = 0;
  always #5 clk_i = ~clk_i;
  host_port_pin_io u_host_port_pin_io (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mux8_mode_i(mux8_mode_i), .mux16_mode_i(mux16_mode_i), .port_enable_pin_i(port_enable_pin_i),
    .host_strobe_internal_n_i(strobe_n), .fifo_ready_i(fifo_ready_i), .dma_busy_i(dma_busy_i),
    .emu_suspend_i(emu_suspend_i), .idle_grant_i(idle_grant_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o), .pin_gpio_sel_o(pin_gpio_sel_o), .host_ready_o(host_ready_o),
    .fifo_reset_o(fifo_reset_o), .dma_halt_o(dma_halt_o), .resume_request_o(resume_request_o),
    .port_stop_o(port_stop_o), .clear_interrupts_o(clear_interrupts_o), .strobe_event_o(strobe_event_o));
  host_model u_host_model (.clk_i(clk_i), .host_ready_i(host_ready_o), .strobe_n_o(strobe_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic pulse(ref logic s, input logic exp);
    logic seen;
    seen = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (s === 1'b1) seen = 1;
    end
    chk(seen, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 4; a <= 'h30; a += 4) begin
      apb(0, a, 0);
      chk(rd, 0);
    end
    apb(0, `HP_OFF_CONTROL, 0);
    chk(rd, 32'h8);
    apb(0, 8'h40, 0);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    $display("done reset values");
    apb(1, `HP_OFF_DIR_1, 32'hff0f);
    apb(1, `HP_OFF_FSEL_LO, 32'hffff);
    apb(1, `HP_OFF_LEVEL_1, 32'h5);
    pin_in_i[7:4] <= 4'ha;
    repeat (6) @(posedge clk_i);
    chk({pin_gpio_sel_o[15:0], pin_oe_n_o[15:0]}, 32'h00ff_fff0);
    chk(pin_out_o[3:0], 4'h5);
    apb(0, `HP_OFF_LEVEL_1, 0);
    chk(rd, 32'ha5);
    mux8_mode_i <= 0;
    mux16_mode_i <= 1;
    repeat (3) @(posedge clk_i);
    chk({pin_gpio_sel_o[7:0], pin_oe_n_o[7:0]}, 16'h00ff);
    mux8_mode_i <= 1;
    mux16_mode_i <= 0;
    apb(1, `HP_OFF_FSEL_HI, 32'h1ff);
    repeat (6) @(posedge clk_i);
    chk(pin_gpio_sel_o[40:32], 9'h1ff);
    port_enable_pin_i <= 1;
    repeat (6) @(posedge clk_i);
    chk(pin_gpio_sel_o[40:32], 9'h01f);
    $display("done pin ownership");
    apb(1, `HP_OFF_STB_INT_1, 32'h1);
    pin_in_i[33] <= 1;
    pulse(strobe_event_o, 1);
    apb(1, `HP_OFF_STB_INT_2, 32'h1);
    pin_in_i[33] <= 0;
    pulse(strobe_event_o, 1);
    apb(1, `HP_OFF_STB_INT_1, 32'h0);
    apb(1, `HP_OFF_STB_INT_2, 32'h0);
    pin_in_i[33] <= 1;
    pulse(strobe_event_o, 0);
    $display("done strobe interrupt");
    idle_grant_i <= 1;
    repeat (3) @(posedge clk_i);
    chk({port_stop_o, host_ready_o}, 2'b10);
    idle_grant_i <= 0;
    for (int m = 0; m < 4; m++) begin
      apb(1, `HP_OFF_PWR_EMU, m);
      emu_suspend_i <= 1;
      repeat (4) @(posedge clk_i);
      chk(dma_halt_o, m == 2);
      emu_suspend_i <= 0;
      pulse(resume_request_o, m == 2);
    end
    $display("done idle and suspend");
    fifo_ready_i <= 0;
    repeat (3) @(posedge clk_i);
    chk(host_ready_o, 0);
    fork
      u_host_model.cycle(2);
    join_none
    repeat (3) @(posedge clk_i);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    chk(host_ready_o, 1);
    repeat (8) @(posedge clk_i);
    chk(host_ready_o, 0);
    rst_i <= 0;
    apb(0, `HP_OFF_FSEL_LO, 0);
    chk(rd, 0);
    $display("done device reset");
    fifo_ready_i <= 1;
    apb(1, `HP_OFF_FSEL_LO, 32'h3);
    apb(1, `HP_OFF_CONTROL, 32'h80);
    pulse(fifo_reset_o, 1);
    apb(0, `HP_OFF_FSEL_LO, 0);
    chk(rd, 32'h3);
    fifo_ready_i <= 0;
    dma_busy_i <= 1;
    fork
      u_host_model.cycle(3);
    join_none
    apb(1, `HP_OFF_CONTROL, 32'h80);
    apb(1, `HP_OFF_CONTROL, 32'h0);
    apb(0, `HP_OFF_STATUS, 0);
    chk(rd[2], 1);
    apb(0, `HP_OFF_CONTROL, 0);
    chk({rd[7], host_ready_o}, 2'b00);
    dma_busy_i <= 0;
    pulse(fifo_reset_o, 1);
    fifo_ready_i <= 1;
    $display("done soft reset");
    finish_test;
  end
endmodule // host_port_pin_io_tb
bind host_port_pin_io host_port_pin_io_sva u_host_port_pin_io_sva (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .mux8_mode_i(mux8_mode_i),
  .port_enable_pin_i(port_enable_pin_i), .host_strobe_internal_n_i(host_strobe_internal_n_i),
  .fifo_ready_i(fifo_ready_i), .dma_busy_i(dma_busy_i), .emu_suspend_i(emu_suspend_i),
  .idle_grant_i(idle_grant_i), .pin_oe_n_o(pin_oe_n_o), .pin_gpio_sel_o(pin_gpio_sel_o),
  .host_ready_o(host_ready_o), .fifo_reset_o(fifo_reset_o), .dma_halt_o(dma_halt_o),
  .resume_request_o(resume_request_o), .port_stop_o(port_stop_o), .clear_interrupts_o(clear_interrupts_o),
  .strobe_event_o(strobe_event_o));
